// ---- dv/crsc_board_model.sv ----
// Board side of the start-up control: reset sources and the PLL clock level.
// Assumes the bench asks for reset holds at the falling edge of clk.
`timescale 1ns/1ps
module crsc_board_model (
  input wire logic clk,
  input wire logic holdReset,
  input wire logic holdTapReset,
  output logic extResetN,
  output logic testResetN,
  output logic pllClockLevel
);
  logic [2:0] pwrCnt = 3'h0;
  logic pllLevel = 1'b0;
  wire pwrDone = (pwrCnt == 3'h7);
  always @(negedge clk) begin
    if (!pwrDone) pwrCnt <= pwrCnt + 3'h1;
    pllLevel <= ~pllLevel;
  end
  // Both resets stay low through power-up
  assign extResetN = pwrDone && !holdReset;
  assign testResetN = pwrDone && !holdTapReset;
  // Toggles every cycle so a late or stale copy shows at once
  assign pllClockLevel = pllLevel;
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the start-up clock and reset control top.
// Assumes the board model supplies resets; inputs change at falling clk.
`timescale 1ns/1ps
`include "crsc_regs.svh"
module tb;
  localparam int LOCK = 8;
  typedef struct {logic [1:0] code; logic [5:0] mult; logic byp;} crsc_row_t;
  crsc_row_t rows [4] = '{'{2'h0, 6'h03, 1'b0}, '{2'h1, 6'h10, 1'b0},
    '{2'h2, 6'h08, 1'b0}, '{2'h3, 6'h01, 1'b1}};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic holdReset = 1'b1;
  logic holdTapReset = 1'b0;
  logic [1:0] coreRatioSelect = 2'h0;
  logic pmWrite = 1'b0;
  logic [`CRSC_PM_WIDTH-1:0] pmWriteData = 16'h0000;
  logic testClock = 1'b0;
  logic testModeSelect = 1'b1;
  logic testDataIn = 1'b1;
  logic extResetN, testResetN, pllClockLevel, pllPrev;
  logic testDataOut, testDataOutEn, resetOrClockOut, coreResetN, coreStart;
  logic pllBypass;
  logic [23:0] coreStartVector;
  logic [5:0] pllMult;
  logic [1:0] pllDiv;
  logic [15:0] powerMgmtControl;
  logic o, oe, seen;
  logic [3:0] irOut, enOut;
  int fails = 0;
  int totalChecks = 0;
  int n;
  always #20 clk = ~clk;
  always @(posedge clk) pllPrev <= pllClockLevel;
  crsc_board_model crsc_board_model_i (.clk(clk), .holdReset(holdReset),
    .holdTapReset(holdTapReset), .extResetN(extResetN), .testResetN(testResetN),
    .pllClockLevel(pllClockLevel));
  crsc_top #(.LOCK_CYCLES(LOCK)) crsc_top_i (.clk(clk), .rstn(rstn), .ce(ce),
    .extResetN(extResetN), .coreRatioSelect(coreRatioSelect),
    .pllClockLevel(pllClockLevel), .pmWrite(pmWrite), .pmWriteData(pmWriteData),
    .testClock(testClock), .testResetN(testResetN), .testModeSelect(testModeSelect),
    .testDataIn(testDataIn), .testDataOut(testDataOut), .testDataOutEn(testDataOutEn),
    .resetOrClockOut(resetOrClockOut), .coreResetN(coreResetN), .coreStart(coreStart),
    .coreStartVector(coreStartVector), .pllBypass(pllBypass), .pllMult(pllMult),
    .pllDiv(pllDiv), .powerMgmtControl(powerMgmtControl));
  task automatic chkBit(input logic got, input logic exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkWord(input logic [23:0] got, input logic [23:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic testDone();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cycles(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Test clock stays low between pulses, high 2 and low 3 cycles each
  task automatic tck(input logic m, input logic d);
    testModeSelect = m;
    testDataIn = d;
    testClock = 1'b1;
    cycles(2);
    testClock = 1'b0;
    cycles(3);
    o = testDataOut;
    oe = testDataOutEn;
  endtask
  task automatic pmWr(input logic [15:0] d);
    pmWrite = 1'b1;
    pmWriteData = d;
    cycles(1);
    pmWrite = 1'b0;
    cycles(1);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    testDone();
  end
  initial begin
    cycles(4);
    chkBit(resetOrClockOut, 1'b0);
    chkWord(powerMgmtControl, 24'h0);
    $display("power-up reset test done");
    rstn = 1'b1;
    for (int r = 0; r < 4; r++) begin
      holdReset = 1'b1;
      coreRatioSelect = rows[r].code;
      pmWr(16'h003F);
      cycles(2);
      chkBit(coreResetN, 1'b0);
      chkWord(pllMult, rows[r].mult);
      holdReset = 1'b0;
      n = 0;
      @(negedge clk);
      // Straps moved and words written after release must not count
      coreRatioSelect = ~rows[r].code;
      pmWrite = 1'b1;
      while (coreResetN === 1'b0 && n < 40) begin
        n++;
        @(negedge clk);
      end
      pmWrite = 1'b0;
      // Counted from the edge after the one that sees the release
      chkWord(n, LOCK);
      chkBit(coreStart, 1'b1);
      chkWord(coreStartVector, `CRSC_RESET_VECTOR);
      chkWord(pllMult, rows[r].mult);
      chkBit(pllBypass, rows[r].byp);
      cycles(1);
      chkBit(coreStart, 1'b0);
      chkBit(resetOrClockOut, 1'b1);
      $display("ratio row %0d done", r);
    end
    pmWr(16'h00C5);
    chkWord(pllMult, 24'h05);
    chkWord(pllDiv, 24'h3);
    pmWr(16'h10C5);
    for (int k = 0; k < 4; k++) begin
      chkBit(resetOrClockOut, pllPrev);
      cycles(1);
    end
    pmWr(16'h00C5);
    chkBit(resetOrClockOut, 1'b1);
    // A write while the clock enable is low must leave the word alone
    ce = 1'b0;
    pmWr(16'h0000);
    chkWord(powerMgmtControl, 24'h00C5);
    ce = 1'b1;
    $display("power word test done");
    holdReset = 1'b1;
    cycles(2);
    holdReset = 1'b0;
    seen = 1'b0;
    // Release for four cycles only, then hold again; core must stay in reset
    for (int k = 0; k < 3 * LOCK; k++) begin
      if (k == 4) holdReset = 1'b1;
      cycles(1);
      seen = seen | (coreResetN !== 1'b0);
    end
    chkBit(seen, 1'b0);
    chkBit(resetOrClockOut, 1'b0);
    $display("abort test done");
    tck(1'b0, 1'b1);
    tck(1'b1, 1'b1);
    tck(1'b1, 1'b1);
    tck(1'b0, 1'b1);
    for (int k = 0; k < 4; k++) begin
      tck(1'b0, 1'b1);
      irOut[k] = o;
      enOut[k] = oe;
    end
    chkWord(irOut, 24'h1);
    chkWord(enOut, 24'hF);
    holdTapReset = 1'b1;
    cycles(3);
    chkBit(testDataOutEn, 1'b0);
    holdTapReset = 1'b0;
    // After test reset the bypass bit sits between serial in and out
    tck(1'b0, 1'b1);
    tck(1'b1, 1'b1);
    tck(1'b0, 1'b1);
    tck(1'b0, 1'b1);
    tck(1'b0, 1'b1);
    chkBit(o, 1'b1);
    tck(1'b1, 1'b0);
    chkBit(o, 1'b0);
    chkBit(oe, 1'b0);
    $display("test port done");
    rstn = 1'b0;
    cycles(1);
    chkWord(powerMgmtControl, 24'h0);
    chkBit(coreStart, 1'b0);
    rstn = 1'b1;
    cycles(2);
    chkWord(pllMult, 24'h03);
    chkBit(resetOrClockOut, 1'b0);
    $display("mid-run reset test done");
    testDone();
  end
endmodule

// ---- verilog/crsc_pkg.sv ----
// Types of the start-up clock and reset control block.
// Assumes crsc_regs.svh for numeric constants.
package crsc_pkg;

  typedef enum logic [1:0] {
    SEQ_HELD,
    SEQ_LOCKING,
    SEQ_RUNNING
  } crsc_seq_t;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
    TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } crsc_tap_t;

endpackage

// ---- verilog/crsc_regs.svh ----
// Constants of the start-up clock and reset control block.
// Assumes nothing; definitions only.
`ifndef CRSC_REGS_SVH
`define CRSC_REGS_SVH

// Power management control word layout
`define CRSC_PM_WIDTH 16
`define CRSC_PM_MULT_LSB 0
`define CRSC_PM_MULT_W 6
`define CRSC_PM_DIV_LSB 6
`define CRSC_PM_DIV_W 2
`define CRSC_PM_BYPASS_BIT 8
`define CRSC_PM_PLL_CLOCK_OUT_BIT 12
`define CRSC_PM_RESET 16'h0000

// Start-up ratio codes and their multipliers
`define CRSC_RATIO_X3 2'h0
`define CRSC_RATIO_X16 2'h1
`define CRSC_RATIO_X8 2'h2
`define CRSC_RATIO_RSVD 2'h3
`define CRSC_MULT_X3 6'h03
`define CRSC_MULT_X16 6'h10
`define CRSC_MULT_X8 6'h08
`define CRSC_MULT_X1 6'h01

// PLL lock latency in reference clock cycles
`define CRSC_LOCK_CYCLES 4096
// Hardware reset vector, arbitrary placement
`define CRSC_RESET_VECTOR 24'h090000

// Test logic sizes
`define CRSC_IR_W 4
`define CRSC_IR_BYPASS 4'hF
`define CRSC_BSR_LEN 16

`endif

// ---- verilog/crsc_tap.sv ----
// Boundary-scan test state machine with instruction, bypass and scan path.
// Assumes test clock edges are given as one-cycle strobes of the block clock.
`timescale 1ns/1ps
`include "crsc_regs.svh"
module crsc_tap
  import crsc_pkg::*;
#(
  parameter int BSR_LEN = `CRSC_BSR_LEN
) (
  input wire logic clk,
  input wire logic rstn,
  crsc_tap_if.tap tp
);

  crsc_tap_t state_q, state_d;
  logic [`CRSC_IR_W-1:0] ir_q, irSh_q;
  logic [BSR_LEN-1:0] bsr_q;
  logic byp_q;
  logic tdo_q, tdoEn_q;

  function automatic crsc_tap_t tapNext(input crsc_tap_t s, input logic m);
    unique case (s)
      TAP_RESET: tapNext = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tapNext = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tapNext = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tapNext = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tapNext = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tapNext = m ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tapNext = m ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tapNext = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tapNext = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tapNext = m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tapNext = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tapNext = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tapNext = m ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tapNext = m ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tapNext = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tapNext = m ? TAP_SEL_DR : TAP_IDLE;
    endcase
  endfunction

  wire step = tp.ce & tp.tckRise;
  wire isBypass = (ir_q == `CRSC_IR_BYPASS);
  wire scanBit = (state_q == TAP_SH_IR) ? irSh_q[0] : (isBypass ? byp_q : bsr_q[0]);
  wire shifting = (state_q == TAP_SH_IR) || (state_q == TAP_SH_DR);
  assign state_d = tapNext(state_q, tp.tms);
  assign tp.tdo = tdo_q;
  assign tp.tdoEn = tdoEn_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= TAP_RESET;
    end else if (tp.ce && !tp.trstN) begin
      state_q <= TAP_RESET;
    end else if (step) begin
      state_q <= state_d;
    end
  end

  // Instruction and scan registers move on rising test clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ir_q <= `CRSC_IR_BYPASS;
      irSh_q <= '0;
      bsr_q <= '0;
      byp_q <= 1'b0;
    end else if (tp.ce && (!tp.trstN || (step && state_q == TAP_RESET))) begin
      ir_q <= `CRSC_IR_BYPASS;
    end else if (step) begin
      unique case (state_q)
        TAP_CAP_IR: irSh_q <= 4'h1;
        TAP_SH_IR: irSh_q <= {tp.tdi, irSh_q[`CRSC_IR_W-1:1]};
        TAP_UPD_IR: ir_q <= irSh_q;
        TAP_CAP_DR: byp_q <= 1'b0;
        TAP_SH_DR: begin
          if (isBypass) begin
            byp_q <= tp.tdi;
          end else begin
            bsr_q <= {tp.tdi, bsr_q[BSR_LEN-1:1]};
          end
        end
        default: ;
      endcase
    end
  end

  // Output changes on the falling test clock edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tdo_q <= 1'b0;
      tdoEn_q <= 1'b0;
    end else if (tp.ce && !tp.trstN) begin
      // Test reset must release the serial output at once, not at the next test clock
      tdo_q <= 1'b0;
      tdoEn_q <= 1'b0;
    end else if (tp.ce && tp.tckFall) begin
      tdo_q <= scanBit;
      tdoEn_q <= shifting;
    end
  end

  a_tap_trst_reset: assert property (@(posedge clk) disable iff (!rstn)
    (tp.ce && !tp.trstN) |=> state_q == TAP_RESET)
    else $error("test reset did not reset test state machine");
  a_tap_tms_exit: assert property (@(posedge clk) disable iff (!rstn)
    (step && tp.trstN && state_q == TAP_SH_DR && tp.tms) |=> state_q == TAP_EX1_DR)
    else $error("shift state did not exit on high mode select");
  a_tap_byp_shift: assert property (@(posedge clk) disable iff (!rstn)
    (step && tp.trstN && state_q == TAP_SH_DR && isBypass) |=> byp_q == $past(tp.tdi))
    else $error("bypass bit did not capture serial input");
  a_tap_trst_quiet: assert property (@(posedge clk) disable iff (!rstn)
    (tp.ce && !tp.trstN) |=> !tdoEn_q)
    else $error("test reset left the serial output driven");

endmodule

// ---- verilog/crsc_tap_if.sv ----
// Signals between the control top and its boundary-scan test logic.
// Assumes both ends run on the one block clock.
`timescale 1ns/1ps
interface crsc_tap_if;
  logic ce;
  logic tckRise;
  logic tckFall;
  logic tms;
  logic tdi;
  logic trstN;
  logic tdo;
  logic tdoEn;

  modport top (output ce, output tckRise, output tckFall, output tms, output tdi,
    output trstN, input tdo, input tdoEn);
  modport tap (input ce, input tckRise, input tckFall, input tms, input tdi,
    input trstN, output tdo, output tdoEn);
endinterface

// ---- verilog/crsc_top.sv ----
// Start-up clock and reset control: ratio straps, PLL lock wait, core reset,
// power management word and the shared reset-or-clock pin.
// Assumes all pin inputs are synchronous to clk, the reference clock.
`timescale 1ns/1ps
`include "crsc_regs.svh"
module crsc_top
  import crsc_pkg::*;
#(
  parameter int LOCK_CYCLES = `CRSC_LOCK_CYCLES,
  parameter int BSR_LEN = `CRSC_BSR_LEN,
  parameter logic [23:0] RESET_VECTOR = `CRSC_RESET_VECTOR
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic extResetN,
  input wire logic [1:0] coreRatioSelect,
  input wire logic pllClockLevel,
  input wire logic pmWrite,
  input wire logic [`CRSC_PM_WIDTH-1:0] pmWriteData,
  input wire logic testClock,
  input wire logic testResetN,
  input wire logic testModeSelect,
  input wire logic testDataIn,
  output logic testDataOut,
  output logic testDataOutEn,
  output logic resetOrClockOut,
  output logic coreResetN,
  output logic coreStart,
  output logic [23:0] coreStartVector,
  output logic pllBypass,
  output logic [`CRSC_PM_MULT_W-1:0] pllMult,
  output logic [`CRSC_PM_DIV_W-1:0] pllDiv,
  output logic [`CRSC_PM_WIDTH-1:0] powerMgmtControl
);

  localparam int CNT_W = $clog2(LOCK_CYCLES + 1);
  localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYCLES - 1);

  function automatic logic [`CRSC_PM_MULT_W-1:0] ratioMult(input logic [1:0] code);
    unique case (code)
      `CRSC_RATIO_X3: ratioMult = `CRSC_MULT_X3;
      `CRSC_RATIO_X16: ratioMult = `CRSC_MULT_X16;
      `CRSC_RATIO_X8: ratioMult = `CRSC_MULT_X8;
      `CRSC_RATIO_RSVD: ratioMult = `CRSC_MULT_X1;
    endcase
  endfunction

  crsc_seq_t seq_q, seq_d;
  logic [CNT_W-1:0] lockCnt_q;
  logic [`CRSC_PM_WIDTH-1:0] pm_q, pm_d;
  logic coreResetN_q, coreStart_q, pin_q, tck_q;
  logic [23:0] vector_q;

  crsc_tap_if tapBus ();

  // Strap decode: the reserved code bypasses the PLL so the core still runs
  wire [`CRSC_PM_MULT_W-1:0] strapMult = ratioMult(coreRatioSelect);
  wire strapBypass = (coreRatioSelect == `CRSC_RATIO_RSVD);
  wire released = extResetN;
  wire lockDone = (lockCnt_q == LOCK_LAST);
  wire running = (seq_q == SEQ_RUNNING);
  wire clkOutSel = pm_q[`CRSC_PM_PLL_CLOCK_OUT_BIT];
  wire pinNext = clkOutSel ? pllClockLevel : coreResetN_q;

  // External reset low at any time returns the whole start-up sequence
  assign seq_d = !released ? SEQ_HELD :
                 (seq_q == SEQ_HELD) ? SEQ_LOCKING :
                 (seq_q == SEQ_LOCKING && lockDone) ? SEQ_RUNNING : seq_q;

  // Straps are caught in the held state, so they count only at release
  assign pm_d = (seq_q == SEQ_HELD) ?
      `CRSC_PM_WIDTH'({strapBypass, 2'h0, strapMult}) :
      (running && pmWrite) ? pmWriteData : pm_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seq_q <= SEQ_HELD;
    end else if (ce) begin
      seq_q <= seq_d;
    end
  end

  // Lock counter runs on the reference clock, which must never stop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lockCnt_q <= '0;
    end else if (ce) begin
      lockCnt_q <= (seq_q == SEQ_LOCKING) ? lockCnt_q + CNT_W'(1) : '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pm_q <= `CRSC_PM_RESET;
    end else if (ce) begin
      pm_q <= pm_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      coreResetN_q <= 1'b0;
      coreStart_q <= 1'b0;
    end else if (ce) begin
      coreResetN_q <= (seq_d == SEQ_RUNNING);
      coreStart_q <= (seq_q == SEQ_LOCKING) && (seq_d == SEQ_RUNNING);
    end
  end

  // Vector kept in a register so that every output leaves a flip-flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vector_q <= RESET_VECTOR;
    end else if (ce) begin
      vector_q <= RESET_VECTOR;
    end
  end

  // Pin shows core reset from power-up until software selects clock; low until the lock wait ends
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_q <= 1'b0;
    end else if (ce) begin
      pin_q <= pinNext;
    end
  end

  // Test clock edges found by sampling; test clock must run far below clk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tck_q <= 1'b0;
    end else if (ce) begin
      tck_q <= testClock;
    end
  end

  assign tapBus.ce = ce;
  assign tapBus.tckRise = testClock & ~tck_q;
  assign tapBus.tckFall = ~testClock & tck_q;
  assign tapBus.tms = testModeSelect;
  assign tapBus.tdi = testDataIn;
  assign tapBus.trstN = testResetN;

  crsc_tap #(
    .BSR_LEN(BSR_LEN)
  ) u_tap (
    .clk(clk),
    .rstn(rstn),
    .tp(tapBus)
  );

  assign testDataOut = tapBus.tdo;
  assign testDataOutEn = tapBus.tdoEn;
  assign resetOrClockOut = pin_q;
  assign coreResetN = coreResetN_q;
  assign coreStart = coreStart_q;
  assign coreStartVector = vector_q;
  assign pllBypass = pm_q[`CRSC_PM_BYPASS_BIT];
  assign pllMult = pm_q[`CRSC_PM_MULT_LSB +: `CRSC_PM_MULT_W];
  assign pllDiv = pm_q[`CRSC_PM_DIV_LSB +: `CRSC_PM_DIV_W];
  assign powerMgmtControl = pm_q;

  sequence s_release;
    ce && seq_q == SEQ_HELD && extResetN;
  endsequence

  sequence s_lock_end;
    ce && seq_q == SEQ_LOCKING && lockDone && extResetN;
  endsequence

  a_release_lock_start: assert property (@(posedge clk) disable iff (!rstn)
    s_release |=> seq_q == SEQ_LOCKING && lockCnt_q == '0)
    else $error("release did not start the lock wait");
  a_lock_end_start: assert property (@(posedge clk) disable iff (!rstn)
    s_lock_end |=> coreStart_q && coreResetN_q ##1 (!coreStart_q || !ce))
    else $error("core did not start cleanly after lock wait");
  a_reset_held_lock: assert property (@(posedge clk) disable iff (!rstn)
    (seq_q != SEQ_RUNNING) |-> !coreResetN_q)
    else $error("core reset released before lock completed");
  a_start_count_len: assert property (@(posedge clk) disable iff (!rstn)
    $rose(coreResetN_q) |-> $past(lockCnt_q) == LOCK_LAST)
    else $error("lock wait length wrong");
  a_strap_decode: assert property (@(posedge clk) disable iff (!rstn)
    (ce && seq_q == SEQ_HELD) |=>
      pllMult == ratioMult($past(coreRatioSelect)) &&
      pllBypass == ($past(coreRatioSelect) == `CRSC_RATIO_RSVD))
    else $error("start-up ratio decode wrong");
  a_pm_write_take: assert property (@(posedge clk) disable iff (!rstn)
    (ce && running && extResetN && pmWrite) |=> pm_q == $past(pmWriteData))
    else $error("power management write not taken");
  a_pin_reset_mode: assert property (@(posedge clk) disable iff (!rstn)
    (ce && !clkOutSel) |=> resetOrClockOut == $past(coreResetN_q))
    else $error("pin does not follow core reset");
  a_pin_clock_mode: assert property (@(posedge clk) disable iff (!rstn)
    (ce && clkOutSel) |=> resetOrClockOut == $past(pllClockLevel))
    else $error("pin does not follow PLL clock");
  a_abort_core_held: assert property (@(posedge clk) disable iff (!rstn)
    (ce && !extResetN) |=> seq_q == SEQ_HELD && !coreResetN_q)
    else $error("external reset did not hold the core");
  a_pm_lock_refuse: assert property (@(posedge clk) disable iff (!rstn)
    (ce && seq_q == SEQ_LOCKING) |=> $stable(pm_q))
    else $error("power management word changed during lock wait");
  a_pin_default_reset: assert property (@(posedge clk) disable iff (!rstn)
    (ce && seq_q == SEQ_HELD) |=> !clkOutSel)
    else $error("pin not in reset mode after reset");
  a_vector_at_start: assert property (@(posedge clk) disable iff (!rstn)
    coreStart_q |-> coreStartVector == RESET_VECTOR)
    else $error("start vector wrong at core start");
  a_ce_state_freeze: assert property (@(posedge clk) disable iff (!rstn)
    !ce |=> $stable(seq_q) && $stable(lockCnt_q) && $stable(pm_q) && $stable(pin_q))
    else $error("state moved while clock enable low");

endmodule
